/* core/pcdl_pkg.sv */
// shared constants and types of the core voltage and regulator register bank
package pcdl_pkg;
  // register addresses on the serial register port
  localparam logic [7:0] ADDR_CONV_CTRL_ONE  = 8'h04;
  localparam logic [7:0] ADDR_CONV_CTRL_TWO  = 8'h05;
  localparam logic [7:0] ADDR_CORE_TARGET    = 8'h06;
  localparam logic [7:0] ADDR_CORE_SLEW      = 8'h07;
  localparam logic [7:0] ADDR_REG_VOLTAGE    = 8'h08;
  // converter control two fields
  localparam int         CC2_GO_BIT          = 7;
  localparam int         CC2_PIN_SEL_BIT     = 6;
  localparam logic [7:0] CC2_RESET           = 8'h40;
  // regulator voltage fields, bits 7 and 3 reserved
  localparam logic [7:0] REG_VOLTAGE_MASK    = 8'h77;
  // core voltage code defaults: pin low 1.3 V, pin high 1.55 V
  localparam logic [4:0] CORE_DEF_GND        = 5'h14;
  localparam logic [4:0] CORE_DEF_VCC        = 5'h1E;
  localparam logic [4:0] CORE_CODE_MAX       = 5'h1F;
  // slew select
  localparam logic [2:0] SLEW_RESET          = 3'h6;
  localparam logic [2:0] SLEW_IMMEDIATE      = 3'h7;
  localparam int         SLEW_FASTEST_SHIFT  = 6;
  // ramp timing: one code is 25 mV, slowest rate 0.225 mV/us
  localparam int         STEP_UV             = 25000;
  localparam int         SLOW_RATE_UV_PER_US = 225;
  localparam int         CLK_PERIOD_NS       = 10;
  localparam int         SLOW_STEP_NS        = STEP_UV * 1000 / SLOW_RATE_UV_PER_US;
  localparam int         SLOW_STEP_CYC       = SLOW_STEP_NS / CLK_PERIOD_NS;
  localparam int         TIMER_W             = 16;
  // regulator defaults indexed by {reg_b pin, reg_a pin}
  localparam logic [7:0] REG_DEF_00          = 8'h00;
  localparam logic [7:0] REG_DEF_01          = 8'h03;
  localparam logic [7:0] REG_DEF_10          = 8'h30;
  localparam logic [7:0] REG_DEF_11          = 8'h77;

  typedef enum logic [1:0] {
    PCDL_IDLE = 2'b01,
    PCDL_RAMP = 2'b10
  } pcdl_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcdl_bus_t;

  typedef struct packed {
    logic [2:0]         forced_fixed_pwm;
    logic               go;
    logic               pin_sel;
    logic [2:0]         dis;
    logic [4:0]         target;
    logic [2:0]         slew;
    logic [7:0]         ldo;
    logic [4:0]         code;
    logic [TIMER_W-1:0] timer;
    pcdl_state_t        st;
    logic [7:0]         rdata;
  } pcdl_regs_t;
endpackage

/* core/pcdl_regs.sv */
// core voltage change, discharge and regulator code register bank
`timescale 1ns/10ps

// How it works
// - bits 2,1,0 of address 04h force fixed PWM on system, core, memory bucks.
// - converter control two at 05h, read/write, default 40h.
// - writing 1 to bit 7 starts the core ramp; writing 0 does nothing.
// - trigger clears itself when the internal code reaches the target.
// - pin-default select bit 6 returns to 1 on any of four default events.
// - select 0 uses the register code; select 1 lets the default pin decide.
// - discharge bits discharge a converter output only while it is disabled.
// - core target at 06h, default 14h or 1Eh by pin, bits 7:5 read zero.
// - core target reloads its default on any of the four default events.
// - core code 0 is 0.8 V, 25 mV per code, code 31 is 1.575 V.
// - slew select at 07h, bits 2:0, default 06h, reloaded on undervoltage.
// - slew codes 0 to 6 double the rate from 0.225 mV/us; 7 is immediate.
// - regulator voltage at 08h, default from two pins, reloaded on undervoltage.
// - regulator b code in bits 6:4 selects 1.05 V up to 3.3 V.
// - regulator a code in bits 2:0 selects 1.0 V up to 3.15 V.
module pcdl_regs
  import pcdl_pkg::*;
#(
  parameter int SLOW_STEP_CYCLES = SLOW_STEP_CYC
)(
  // clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  // register port from the serial engine
  input  wire pcdl_bus_t  bus_in,
  output logic [7:0]      rdata_out,
  // default-loading events
  input  wire logic       undervoltage_lockout_in,
  input  wire logic       warm_reset_input_n_in,
  input  wire logic       power_on_reset_output_in,
  input  wire logic       backup_rail_low_in,
  // default pins
  input  wire logic       core_default_pin_in,
  input  wire logic       reg_a_default_pin_in,
  input  wire logic       reg_b_default_pin_in,
  // converter enables: system, core, memory
  input  wire logic [2:0] conv_enabled_in,
  // converter controls
  output logic [2:0]      forced_fixed_pwm_out,
  output logic [2:0]      discharge_active_out,
  output logic            core_use_pin_out,
  output logic [4:0]      core_rail_code_out,
  output logic            core_ramp_busy_out,
  output logic [2:0]      linear_reg_a_code_out,
  output logic [2:0]      linear_reg_b_code_out
);

  if (SLOW_STEP_CYCLES >= (1 << TIMER_W))
  begin : g_timer_fit
    $error("SLOW_STEP_CYCLES does not fit the step timer");
  end
  if ((SLOW_STEP_CYCLES >> SLEW_FASTEST_SHIFT) < 1)
  begin : g_fast_fit
    $error("SLOW_STEP_CYCLES too small for the fastest slew");
  end

  pcdl_regs_t r_ff;
  pcdl_regs_t nxt_r;
  logic       rst_evt;
  logic [4:0] core_def;
  logic [7:0] reg_def;
  logic       wr_cc1;
  logic       wr_cc2;
  logic       wr_tgt;
  logic       wr_slew;
  logic       wr_reg;

  function automatic logic [TIMER_W-1:0] step_cycles(input logic [2:0] s);
    // interval halves as the rate doubles; minus one for a down counter
    return TIMER_W'((SLOW_STEP_CYCLES >> s) - 1);
  endfunction

  assign rst_evt  = undervoltage_lockout_in | ~warm_reset_input_n_in
                  | power_on_reset_output_in | backup_rail_low_in;
  assign core_def = core_default_pin_in ? CORE_DEF_VCC : CORE_DEF_GND;
  assign wr_cc1   = bus_in.wr && (bus_in.addr == ADDR_CONV_CTRL_ONE);
  assign wr_cc2   = bus_in.wr && (bus_in.addr == ADDR_CONV_CTRL_TWO);
  assign wr_tgt   = bus_in.wr && (bus_in.addr == ADDR_CORE_TARGET);
  assign wr_slew  = bus_in.wr && (bus_in.addr == ADDR_CORE_SLEW);
  assign wr_reg   = bus_in.wr && (bus_in.addr == ADDR_REG_VOLTAGE);

  always_comb
  begin
    case ({reg_b_default_pin_in, reg_a_default_pin_in})
      2'b00:   reg_def = REG_DEF_00;
      2'b01:   reg_def = REG_DEF_01;
      2'b10:   reg_def = REG_DEF_10;
      default: reg_def = REG_DEF_11;
    endcase
  end

  always_comb
  begin
    nxt_r = r_ff;
    if (wr_cc1)
      nxt_r.forced_fixed_pwm = bus_in.wdata[2:0];
    if (wr_cc2)
    begin
      nxt_r.pin_sel = bus_in.wdata[CC2_PIN_SEL_BIT];
      nxt_r.dis     = bus_in.wdata[2:0];
    end
    // only five code bits are stored
    if (wr_tgt)
      nxt_r.target = bus_in.wdata[4:0];
    if (wr_slew)
      nxt_r.slew = bus_in.wdata[2:0];
    if (wr_reg)
      nxt_r.ldo = bus_in.wdata & REG_VOLTAGE_MASK;

    case (r_ff.st)
      PCDL_IDLE:
      begin
        if (r_ff.go)
        begin
          nxt_r.st    = PCDL_RAMP;
          nxt_r.timer = step_cycles(r_ff.slew);
        end
      end
      PCDL_RAMP:
      begin
        if (r_ff.code == r_ff.target)
        begin
          // done on code match, not on regulation
          nxt_r.go = 1'b0;
          nxt_r.st = PCDL_IDLE;
        end
        // immediate setting jumps in one step
        else if (r_ff.slew == SLEW_IMMEDIATE)
          nxt_r.code = r_ff.target;
        else if (r_ff.timer == '0)
        begin
          nxt_r.timer = step_cycles(r_ff.slew);
          if (r_ff.code < r_ff.target)
            nxt_r.code = r_ff.code + 5'h01;
          else
            nxt_r.code = r_ff.code - 5'h01;
        end
        else
          nxt_r.timer = r_ff.timer - TIMER_W'(1);
      end
      default:
      begin
        nxt_r.st = PCDL_IDLE;
      end
    endcase

    // a written 1 starts a change and beats the self clear
    if (wr_cc2 && bus_in.wdata[CC2_GO_BIT])
      nxt_r.go = 1'b1;

    if (rst_evt)
    begin
      nxt_r.pin_sel = CC2_RESET[CC2_PIN_SEL_BIT];
      nxt_r.target  = core_def;
    end
    if (undervoltage_lockout_in)
    begin
      nxt_r.forced_fixed_pwm  = '0;
      nxt_r.go    = CC2_RESET[CC2_GO_BIT];
      nxt_r.dis   = CC2_RESET[2:0];
      nxt_r.slew  = SLEW_RESET;
      nxt_r.ldo   = reg_def;
      nxt_r.code  = core_def;
      nxt_r.timer = '0;
      nxt_r.st    = PCDL_IDLE;
    end

    // read data registered on the read strobe, unmapped reads give zero
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        ADDR_CONV_CTRL_ONE: nxt_r.rdata = {5'h00, r_ff.forced_fixed_pwm};
        ADDR_CONV_CTRL_TWO: nxt_r.rdata = {r_ff.go, r_ff.pin_sel, 3'h0, r_ff.dis};
        ADDR_CORE_TARGET:   nxt_r.rdata = {3'h0, r_ff.target};
        ADDR_CORE_SLEW:     nxt_r.rdata = {5'h00, r_ff.slew};
        ADDR_REG_VOLTAGE:   nxt_r.rdata = r_ff.ldo;
        default:            nxt_r.rdata = 8'h00;
      endcase
    end
  end

  // reset holds the gnd-pin core default; the pin level is taken on events
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      r_ff.forced_fixed_pwm    <= '0;
      r_ff.go      <= CC2_RESET[CC2_GO_BIT];
      r_ff.pin_sel <= CC2_RESET[CC2_PIN_SEL_BIT];
      r_ff.dis     <= CC2_RESET[2:0];
      r_ff.target  <= CORE_DEF_GND;
      r_ff.slew    <= SLEW_RESET;
      r_ff.ldo     <= REG_DEF_00;
      r_ff.code    <= CORE_DEF_GND;
      r_ff.timer   <= '0;
      r_ff.st      <= PCDL_IDLE;
      r_ff.rdata   <= 8'h00;
    end
    else if (ce_in)
      r_ff <= nxt_r;
  end

  // pwm selects straight from the register
  assign forced_fixed_pwm_out  = r_ff.forced_fixed_pwm;
  // discharge only while the converter is off
  assign discharge_active_out  = r_ff.dis & ~conv_enabled_in;
  // code drives the core buck unless the pin decides
  assign core_use_pin_out      = r_ff.pin_sel;
  assign core_rail_code_out    = r_ff.code;
  assign core_ramp_busy_out    = r_ff.go;
  assign linear_reg_b_code_out = r_ff.ldo[6:4];
  assign linear_reg_a_code_out = r_ff.ldo[2:0];
  assign rdata_out             = r_ff.rdata;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // the clear can lose only to a same-cycle write or undervoltage
  sequence s_ramp_done;
    ce_in && r_ff.st == PCDL_RAMP && r_ff.code == r_ff.target && !wr_cc2
      && !undervoltage_lockout_in;
  endsequence

  sequence s_go_start;
    ce_in && wr_cc2 && bus_in.wdata[CC2_GO_BIT] && !undervoltage_lockout_in
      && r_ff.st == PCDL_IDLE;
  endsequence

  sequence s_go_armed;
    ce_in && !undervoltage_lockout_in;
  endsequence

  // still moving on a counted slew, nothing reloading the code
  sequence s_ramp_step;
    ce_in && r_ff.st == PCDL_RAMP && r_ff.code != r_ff.target
      && r_ff.slew != SLEW_IMMEDIATE && !undervoltage_lockout_in;
  endsequence

  a_go_self_clear: assert property (
      s_ramp_done |=> !r_ff.go)
    else $error("trigger not cleared after code match");

  a_go_start_ramp: assert property (
      s_go_start ##1 s_go_armed |=> r_ff.st == PCDL_RAMP)
    else $error("written trigger did not start the ramp");

  a_go_zero_noop: assert property (
      ce_in && wr_cc2 && !bus_in.wdata[CC2_GO_BIT] && !r_ff.go
      && r_ff.st == PCDL_IDLE |=> !r_ff.go && r_ff.st == PCDL_IDLE)
    else $error("writing zero to trigger changed state");

  a_ramp_one_step: assert property (
      r_ff.code != $past(r_ff.code) && $past(r_ff.slew) != SLEW_IMMEDIATE
      && !$past(undervoltage_lockout_in)
      |-> (r_ff.code == $past(r_ff.code) + 5'h01
           || r_ff.code == $past(r_ff.code) - 5'h01))
    else $error("ramp moved by more than one code");

  a_ramp_hold: assert property (
      s_ramp_step ##0 (r_ff.timer != '0) |=> r_ff.code == $past(r_ff.code))
    else $error("code moved before the slew interval ran out");

  a_ramp_up: assert property (
      s_ramp_step ##0 (r_ff.code < r_ff.target) |=> r_ff.code >= $past(r_ff.code))
    else $error("ramp moved away from a higher target");

  a_slew_immediate: assert property (
      ce_in && r_ff.st == PCDL_RAMP && r_ff.slew == SLEW_IMMEDIATE
      && !undervoltage_lockout_in |=> r_ff.code == $past(r_ff.target))
    else $error("immediate slew did not load target");

  a_ce_freeze: assert property (
      !ce_in |=> r_ff.code == $past(r_ff.code) && r_ff.go == $past(r_ff.go)
      && rdata_out == $past(rdata_out))
    else $error("state moved while the clock enable was low");

  a_pin_sel_event: assert property (
      ce_in && rst_evt |=> r_ff.pin_sel && r_ff.target == $past(core_def))
    else $error("default event did not reload select and target");

  a_target_default: assert property (
      ce_in && rst_evt
      |=> r_ff.target == ($past(core_default_pin_in) ? CORE_DEF_VCC : CORE_DEF_GND))
    else $error("default event loaded the wrong core target");

  a_slew_reload: assert property (
      ce_in && undervoltage_lockout_in
      |=> r_ff.slew == SLEW_RESET && r_ff.ldo == $past(reg_def) && !r_ff.go)
    else $error("undervoltage did not reload slew and regulator");

  a_pwm_write: assert property (
      ce_in && wr_cc1 && !undervoltage_lockout_in
      |=> forced_fixed_pwm_out == $past(bus_in.wdata[2:0]))
    else $error("forced pwm selects not taken from the write");

  a_cc2_write: assert property (
      ce_in && wr_cc2 && !rst_evt
      |=> r_ff.pin_sel == $past(bus_in.wdata[CC2_PIN_SEL_BIT])
          && r_ff.dis == $past(bus_in.wdata[2:0]))
    else $error("converter control two write not stored");

  a_cc2_read: assert property (
      ce_in && bus_in.rd && bus_in.addr == ADDR_CONV_CTRL_TWO
      |=> rdata_out[5:3] == 3'h0 && rdata_out[7] == $past(r_ff.go)
          && rdata_out[6] == $past(r_ff.pin_sel))
    else $error("converter control two read back wrong");

  a_target_write: assert property (
      ce_in && wr_tgt && !rst_evt |=> r_ff.target == $past(bus_in.wdata[4:0]))
    else $error("core target write not stored");

  a_target_read: assert property (
      ce_in && bus_in.rd && bus_in.addr == ADDR_CORE_TARGET
      |=> rdata_out[7:5] == 3'h0 && rdata_out[4:0] == $past(r_ff.target))
    else $error("target read back wrong");

  a_slew_write: assert property (
      ce_in && wr_slew && !undervoltage_lockout_in
      |=> r_ff.slew == $past(bus_in.wdata[2:0]))
    else $error("slew write not stored");

  a_reg_b_write: assert property (
      ce_in && wr_reg && !undervoltage_lockout_in
      |=> linear_reg_b_code_out == $past(bus_in.wdata[6:4]))
    else $error("regulator b code not taken from the write");

  a_reg_a_write: assert property (
      ce_in && wr_reg && !undervoltage_lockout_in
      |=> linear_reg_a_code_out == $past(bus_in.wdata[2:0]))
    else $error("regulator a code not taken from the write");

  a_reg_reserved: assert property (
      linear_reg_a_code_out == r_ff.ldo[2:0] && r_ff.ldo[7] == 1'b0
      && r_ff.ldo[3] == 1'b0)
    else $error("reserved regulator bits set");

  a_discharge_gate: assert property (
      (discharge_active_out & conv_enabled_in) == 3'h0)
    else $error("discharge while a converter is enabled");

  a_discharge_idle: assert property (
      !conv_enabled_in[0] && r_ff.dis[0] |-> discharge_active_out[0])
    else $error("no discharge on a disabled converter");

endmodule

/* bench/pcdl_host.sv */
// host model driving the register port of the core voltage register bank
`timescale 1ns/10ps
module pcdl_host
  import pcdl_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // register port
  output pcdl_bus_t       bus_out,
  input  wire logic [7:0] rdata_in
);
  initial bus_out = '0;

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    bus_out.addr = addr;
    bus_out.wdata = (addr == ADDR_REG_VOLTAGE) ? (data & REG_VOLTAGE_MASK) : data;
    bus_out.wr = 1'b1;
    @(negedge clk_in);
    bus_out.wr = 1'b0;
    // released lines must not keep showing the last byte
    bus_out.wdata = ~bus_out.wdata;
  endtask

  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_in);
    bus_out.addr = addr;
    bus_out.rd = 1'b1;
    @(negedge clk_in);
    bus_out.rd = 1'b0;
    bus_out.addr = ~addr;
    @(negedge clk_in);
    data = rdata_in;
  endtask
endmodule

/* bench/test_pcdl_regs.sv */
// self-checking bench of the core voltage register bank
`timescale 1ns/10ps
module test_pcdl_regs
  import pcdl_pkg::*;
;
  logic clk_in = 1'b0, reset_n_in = 1'b0, undervoltage_lockout = 1'b0, warm_n = 1'b1, por = 1'b0, vlow = 1'b0;
  logic core_pin = 1'b0, a_pin = 1'b1, b_pin = 1'b0, ce = 1'b1;
  logic [2:0] conv_en = 3'h0;
  pcdl_bus_t bus;
  logic [7:0] rdata;
  logic [2:0] forced_fixed_pwm, dis, ra, rb;
  logic use_pin, busy;
  logic [4:0] code;
  int fails = 0, num_checks = 0, cnt;

  always #5 clk_in = ~clk_in;

  pcdl_regs #(.SLOW_STEP_CYCLES(64)) pcdl_regs_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce), .bus_in(bus), .rdata_out(rdata),
    .undervoltage_lockout_in(undervoltage_lockout), .warm_reset_input_n_in(warm_n),
    .power_on_reset_output_in(por), .backup_rail_low_in(vlow),
    .core_default_pin_in(core_pin), .reg_a_default_pin_in(a_pin),
    .reg_b_default_pin_in(b_pin), .conv_enabled_in(conv_en),
    .forced_fixed_pwm_out(forced_fixed_pwm), .discharge_active_out(dis), .core_use_pin_out(use_pin),
    .core_rail_code_out(code), .core_ramp_busy_out(busy),
    .linear_reg_a_code_out(ra), .linear_reg_b_code_out(rb));

  pcdl_host pcdl_host_inst (.clk_in(clk_in), .bus_out(bus), .rdata_in(rdata));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    pcdl_host_inst.rd_reg(addr, d);
    check(d, exp);
  endtask

  // one-cycle event pulse; sel 0 undervoltage_lockout, 1 warm, 2 por, 3 backup
  task automatic pulse(input int sel);
    @(negedge clk_in);
    {undervoltage_lockout, warm_n, por, vlow} = {sel == 0, sel != 1, sel == 2, sel == 3};
    @(negedge clk_in);
    {undervoltage_lockout, warm_n, por, vlow} = 4'b0100;
  endtask

  // ramp wait, bounded; returns busy cycle count
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0)
    begin
      @(negedge clk_in);
      n++;
      if (n > 400)
      begin
        fails++;
        wrap_up();
      end
    end
  endtask

  initial
  begin
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'b1;
    pulse(0);
    rd_chk(ADDR_CONV_CTRL_ONE, 8'h00);
    rd_chk(ADDR_CONV_CTRL_TWO, 8'h40);
    rd_chk(ADDR_CORE_TARGET, 8'h14);
    rd_chk(ADDR_CORE_SLEW, 8'h06);
    rd_chk(ADDR_REG_VOLTAGE, 8'h03);
    rd_chk(8'h09, 8'h00);
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_ONE, 8'h05);
    @(negedge clk_in);
    check(8'(forced_fixed_pwm), 8'h05);
    // a write with the clock enable low is lost
    ce = 1'b0;
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_ONE, 8'h02);
    ce = 1'b1;
    check(8'(forced_fixed_pwm), 8'h05);
    pcdl_host_inst.wr_reg(ADDR_REG_VOLTAGE, 8'hFF);
    @(negedge clk_in);
    check(8'({rb, ra}), 8'h3F);
    rd_chk(ADDR_REG_VOLTAGE, 8'h77);
    pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'hFF);
    rd_chk(ADDR_CORE_TARGET, 8'h1F);
    // immediate slew, 14h to 16h
    pcdl_host_inst.wr_reg(ADDR_CORE_SLEW, 8'h07);
    pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'h16);
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_TWO, 8'h80);
    wait_idle(cnt);
    check(8'(cnt <= 6), 8'h01);
    check(8'(code), 8'h16);
    rd_chk(ADDR_CONV_CTRL_TWO, 8'h00);
    // slowest slew, two steps down of 64 cycles each
    pcdl_host_inst.wr_reg(ADDR_CORE_SLEW, 8'h00);
    pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'h14);
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_TWO, 8'h80);
    repeat (40) @(negedge clk_in);
    check(8'(code), 8'h16);
    wait_idle(cnt);
    check(8'(cnt + 40 >= 124 && cnt + 40 <= 136), 8'h01);
    check(8'(code), 8'h14);
    // slew code 5, two cycles a code, 14h up to 17h
    pcdl_host_inst.wr_reg(ADDR_CORE_SLEW, 8'h05);
    pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'h17);
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_TWO, 8'h80);
    wait_idle(cnt);
    check(8'(cnt), 8'h08);
    check(8'(code), 8'h17);
    // trigger written 0 starts nothing; discharge only when disabled
    conv_en = 3'h2;
    pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'h18);
    pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_TWO, 8'h07);
    repeat (3) @(negedge clk_in);
    check(8'({busy, use_pin, code}), 8'h17);
    check(8'(dis), 8'h05);
    rd_chk(ADDR_CONV_CTRL_TWO, 8'h07);
    core_pin = 1'b1;
    for (int i = 1; i < 4; i++)
    begin
      pcdl_host_inst.wr_reg(ADDR_CONV_CTRL_TWO, 8'h07);
      pcdl_host_inst.wr_reg(ADDR_CORE_TARGET, 8'h01);
      pulse(i);
      rd_chk(ADDR_CORE_TARGET, 8'h1E);
      rd_chk(ADDR_CONV_CTRL_TWO, 8'h47);
    end
    check(8'(use_pin), 8'h01);
    rd_chk(ADDR_CORE_SLEW, 8'h05);
    {a_pin, b_pin} = 2'b01;
    pulse(0);
    rd_chk(ADDR_CORE_SLEW, 8'h06);
    rd_chk(ADDR_REG_VOLTAGE, 8'h30);
    rd_chk(ADDR_CONV_CTRL_TWO, 8'h40);
    // reset while idle loads constants; pins wait for the next event
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    check(8'({use_pin, busy, code}), 8'h54);
    rd_chk(ADDR_CORE_TARGET, 8'h14);
    pulse(0);
    rd_chk(ADDR_CORE_TARGET, 8'h1E);
    check(8'(code), 8'h1E);
    rd_chk(ADDR_REG_VOLTAGE, 8'h30);
    wrap_up();
  end
endmodule
